// ---- pkg/ucd_pkg.sv ----
/*
 Package for the charger detect and advertise controller: mode codes, ADC result
 format, threshold codes and the packed carriers for the analog switch controls.
 Assumes the ADC delivers an unsigned code scaled so that full scale is 3.6 V.
*/
package ucd_pkg;
   localparam int ADC_W = 10;
   typedef logic [ADC_W-1:0] ucd_adc_t;

   // Requested per-port scheme from configuration
   typedef enum logic [2:0] {
      UCD_CFG_OFF     = 3'h0,
      UCD_CFG_DCD     = 3'h1,
      UCD_CFG_PRI_SEC = 3'h2,
      UCD_CFG_CDP     = 3'h3,
      UCD_CFG_DCP     = 3'h4,
      UCD_CFG_DIV     = 3'h5,
      UCD_CFG_1V2     = 3'h6,
      UCD_CFG_AUTO    = 3'h7
   } ucd_cfg_e;

   // Auto mode candidate presented on the lines
   typedef enum logic [1:0] {
      UCD_AUTO_DCP = 2'h0,
      UCD_AUTO_DIV = 2'h1,
      UCD_AUTO_1V2 = 2'h2
   } ucd_auto_e;

   // ADC codes: 0.6 V nominal seen, low below 0.25 V, full scale 3.6 V
   localparam ucd_adc_t CDP_SEEN_CODE = 10'h0aa;
   localparam ucd_adc_t LINE_LOW_CODE = 10'h047;

   // Dwell per auto candidate before trying the next: 100 ms at 100 MHz
   localparam int AUTO_DWELL_MS = 100;
   localparam int CLK_MHZ = 100;
   localparam int AUTO_DWELL_CYC = AUTO_DWELL_MS * 1000 * CLK_MHZ;

   // Analog element enables
   typedef struct packed {
      logic dplus_contact_current_source;
      logic dminus_pulldown_resistor;
      logic data_line_voltage_source;
      logic data_line_voltage_on_dminus;   // 0: source forced on D+, 1: on D-
      logic data_line_current_sink;
      logic data_line_short_resistor;
      logic divider_on_dplus;
      logic divider_on_dminus;
      logic v1p2_on_dminus;
   } ucd_ana_s;

   localparam ucd_ana_s ANA_OFF = '{default: 1'b0};
endpackage

// ---- rtl/ucd_auto_sel.sv ----
/*
 Auto mode candidate sequencer. Cycles DCP, divider and 1.2 V schemes until the
 attached device settles on one (signalled by the ADC seeing the line loaded).
 Assumes run is held high only while auto mode is selected.
*/
`timescale 1ns/1ns
module ucd_auto_sel #(
   parameter int DWELL_CYC = ucd_pkg::AUTO_DWELL_CYC
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic run,
   input wire logic accepted,
   output ucd_pkg::ucd_auto_e sel
);
   logic [31:0] cnt_q;
   logic lock_q;
   ucd_pkg::ucd_auto_e sel_q;

   assign sel = sel_q;

   // Dwell counter, restarts on every candidate change
   always_ff @(posedge mclk) begin
      if (rst || !run || lock_q || cnt_q == 32'(DWELL_CYC - 1)) begin
         cnt_q <= 32'h0;
      end else begin
         cnt_q <= cnt_q + 32'h1;
      end
   end

   // Lock once the device takes a scheme, release when auto is dropped
   always_ff @(posedge mclk) begin
      if (rst || !run) begin
         lock_q <= 1'b0;
      end else if (accepted) begin
         lock_q <= 1'b1;
      end
   end

   // Candidate rotation; switching lines only, VBUS is untouched
   always_ff @(posedge mclk) begin
      if (rst || !run) begin
         sel_q <= ucd_pkg::UCD_AUTO_DCP;
      end else if (!lock_q && !accepted && cnt_q == 32'(DWELL_CYC - 1)) begin
         unique case (sel_q)
            ucd_pkg::UCD_AUTO_DCP: sel_q <= ucd_pkg::UCD_AUTO_DIV;
            ucd_pkg::UCD_AUTO_DIV: sel_q <= ucd_pkg::UCD_AUTO_1V2;
            default: sel_q <= ucd_pkg::UCD_AUTO_DCP;
         endcase
      end
   end
endmodule

// ---- rtl/ucd_charger_port.sv ----
/*
 Per-port battery charger detect and advertise control: drives the analog
 source, sink and resistor enables on the port D+ and D- lines.
 A port_cfg change passes through an all-off cycle, while auto candidates
 switch over directly; the lines never carry two schemes at once, and the switch enables follow the state by one cycle.
 Auto mode keeps the first candidate that the device loads; dropping and
 reselecting auto, or a reset, is the only way to start the rotation over.
 Assumes the ADC result and its select are handled by a shared converter,
 and that port_cfg is held stable while a scheme is in use.
*/
// Contract
// R1: Data contact detection turns on the D+ current source and D- pull-down, off otherwise.
// R2: Primary/secondary detection forces voltage on one line, sinks the other, then samples it.
// R3: Voltage source and current sink are on throughout primary/secondary detection.
// R4: CDP watches D+ and on 0.6 V drives 0.6 V onto D- until D+ goes low.
// R5: Voltage source and current sink stay on for the whole CDP advertisement.
// R6: DCP advertisement shorts D+ to D- through the short resistor.
// R7: Divider mode puts the divider voltage on both D+ and D-.
// R8: 1.2 V mode drives 1.2 V onto D- and shorts D+ to D-.
// R9: The system should supply at least 2.4 A on VBUS with divider mode.
// R10: The system should supply at least 2 A on VBUS with 1.2 V mode.
// R11: Auto mode places whichever of DCP, divider or 1.2 V the device detects.
// R12: Auto mode changes schemes without discharging VBUS.
// R13: Only one phase or scheme per port at a time, picked by port configuration.
`timescale 1ns/1ns
module ucd_charger_port (
   input wire logic mclk,
   input wire logic rst,
   input wire ucd_pkg::ucd_cfg_e port_cfg,
   input wire logic pri_sec_on_dminus,
   input wire ucd_pkg::ucd_adc_t adc_result,
   input wire logic adc_valid,
   output ucd_pkg::ucd_ana_s ana,
   output logic adc_sel_dminus,
   output logic vbus_discharge,
   output ucd_pkg::ucd_adc_t sense_q,
   output logic sense_valid_q,
   output logic cdp_driving_q
);
   // One-hot phase register; every config code maps to a state
   typedef enum logic [7:0] {
      ST_IDLE = 8'b0000_0001,
      ST_DCD  = 8'b0000_0010,
      ST_PS   = 8'b0000_0100,
      ST_CDP  = 8'b0000_1000,
      ST_DCP  = 8'b0001_0000,
      ST_DIV  = 8'b0010_0000,
      ST_1V2  = 8'b0100_0000,
      ST_AUTO = 8'b1000_0000
   } ucd_st_e;

   ucd_st_e st_q;
   ucd_st_e st_d;
   ucd_pkg::ucd_ana_s ana_q;
   ucd_pkg::ucd_ana_s ana_d;
   ucd_pkg::ucd_auto_e auto_sel;
   logic auto_run;
   logic auto_accept;
   logic dplus_seen;
   logic line_low;

   // Map configuration to a state; one scheme at a time by construction [R13]
   function automatic ucd_st_e cfg_state(input ucd_pkg::ucd_cfg_e c);
      unique case (c)
         ucd_pkg::UCD_CFG_OFF:     cfg_state = ST_IDLE;
         ucd_pkg::UCD_CFG_DCD:     cfg_state = ST_DCD;
         ucd_pkg::UCD_CFG_PRI_SEC: cfg_state = ST_PS;
         ucd_pkg::UCD_CFG_CDP:     cfg_state = ST_CDP;
         ucd_pkg::UCD_CFG_DCP:     cfg_state = ST_DCP;
         ucd_pkg::UCD_CFG_DIV:     cfg_state = ST_DIV;
         ucd_pkg::UCD_CFG_1V2:     cfg_state = ST_1V2;
         ucd_pkg::UCD_CFG_AUTO:    cfg_state = ST_AUTO;
      endcase
   endfunction

   // Shared by the fixed and auto paths so both present identical lines
   function automatic ucd_pkg::ucd_ana_s scheme(input ucd_pkg::ucd_auto_e s);
      scheme = ucd_pkg::ANA_OFF;
      unique case (s)
         ucd_pkg::UCD_AUTO_DCP: begin
            scheme.data_line_short_resistor = 1'b1; // [R6]
         end
         ucd_pkg::UCD_AUTO_DIV: begin
            scheme.divider_on_dplus = 1'b1; // [R7]
            scheme.divider_on_dminus = 1'b1; // [R7]
         end
         default: begin
            scheme.v1p2_on_dminus = 1'b1; // [R8]
            scheme.data_line_short_resistor = 1'b1; // [R8]
         end
      endcase
   endfunction

   // Last line of defence: any element group that does not belong to the
   // state is forced off, so a decode slip cannot load a forced line with
   // a second scheme; costs a few gates in front of the switch flops [R13]
   function automatic ucd_pkg::ucd_ana_s ana_guard(input ucd_st_e s,
      input ucd_pkg::ucd_ana_s a);
      ana_guard = a;
      // Contact detection elements
      if (s != ST_DCD) begin
         ana_guard.dplus_contact_current_source = 1'b0; // [R1]
         ana_guard.dminus_pulldown_resistor = 1'b0; // [R1]
      end
      // Forced voltage and sink, detection and CDP only
      if (!(s inside {ST_PS, ST_CDP})) begin
         ana_guard.data_line_voltage_source = 1'b0; // [R3] [R5]
         ana_guard.data_line_voltage_on_dminus = 1'b0;
         ana_guard.data_line_current_sink = 1'b0; // [R3] [R5]
      end
      // Short resistor
      if (!(s inside {ST_DCP, ST_1V2, ST_AUTO})) begin
         ana_guard.data_line_short_resistor = 1'b0; // [R6] [R8]
      end
      // Divider on both lines
      if (!(s inside {ST_DIV, ST_AUTO})) begin
         ana_guard.divider_on_dplus = 1'b0; // [R7]
         ana_guard.divider_on_dminus = 1'b0; // [R7]
      end
      // 1.2 V source on D-
      if (!(s inside {ST_1V2, ST_AUTO})) begin
         ana_guard.v1p2_on_dminus = 1'b0; // [R8]
      end
   endfunction

   // Config is taken directly; a switch passes through idle for one cycle
   always_comb begin
      st_d = cfg_state(port_cfg);
      if (st_q != ST_IDLE && st_d != st_q) begin
         st_d = ST_IDLE; // break-before-make between schemes [R13]
      end
   end

   // Phase register
   always_ff @(posedge mclk) begin
      if (rst) begin
         st_q <= ST_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   // Threshold compares, shared so CDP and auto judge the line alike
   assign dplus_seen = adc_valid && adc_result >= ucd_pkg::CDP_SEEN_CODE;
   assign line_low = adc_valid && adc_result < ucd_pkg::LINE_LOW_CODE;

   // CDP: latch on 0.6 V at D+, release when D+ falls low [R4]
   always_ff @(posedge mclk) begin
      if (rst || st_q != ST_CDP) begin
         cdp_driving_q <= 1'b0;
      end else if (dplus_seen && !cdp_driving_q) begin
         cdp_driving_q <= 1'b1; // [R4]
      end else if (line_low && cdp_driving_q) begin
         cdp_driving_q <= 1'b0; // [R4]
      end
   end

   // Auto: device pulls the presented level down when it accepts the scheme
   assign auto_run = (st_q == ST_AUTO);
   assign auto_accept = auto_run && line_low;

   ucd_auto_sel u_auto (
      .mclk(mclk),
      .rst(rst),
      .run(auto_run),
      .accepted(auto_accept),
      .sel(auto_sel)
   );

   // Element enables from the current state
   always_comb begin
      ana_d = ucd_pkg::ANA_OFF;
      unique case (st_q)
         ST_IDLE: ana_d = ucd_pkg::ANA_OFF;
         ST_DCD: begin
            ana_d.dplus_contact_current_source = 1'b1; // [R1]
            ana_d.dminus_pulldown_resistor = 1'b1; // [R1]
         end
         ST_PS: begin
            ana_d.data_line_voltage_source = 1'b1; // [R2] [R3]
            ana_d.data_line_current_sink = 1'b1; // [R2] [R3]
            ana_d.data_line_voltage_on_dminus = pri_sec_on_dminus; // [R2]
         end
         ST_CDP: begin
            ana_d.data_line_voltage_source = 1'b1; // [R5]
            ana_d.data_line_current_sink = 1'b1; // [R5]
            ana_d.data_line_voltage_on_dminus = cdp_driving_q; // [R4]
         end
         ST_DCP: ana_d = scheme(ucd_pkg::UCD_AUTO_DCP);
         ST_DIV: ana_d = scheme(ucd_pkg::UCD_AUTO_DIV);
         ST_1V2: ana_d = scheme(ucd_pkg::UCD_AUTO_1V2);
         ST_AUTO: ana_d = scheme(auto_sel); // [R11]
      endcase
   end

   // Registered so the analog switches never see decode glitches
   always_ff @(posedge mclk) begin
      if (rst) begin
         ana_q <= ucd_pkg::ANA_OFF;
      end else begin
         ana_q <= ana_guard(st_q, ana_d); // [R13]
      end
   end
   assign ana = ana_q;

   // Sense line: the line not forced in detection, D+ otherwise [R2]
   assign adc_sel_dminus = (st_q == ST_PS) ? !pri_sec_on_dminus : 1'b0;

   // Never discharge VBUS; scheme changes only move data-line switches [R12]
   assign vbus_discharge = 1'b0;

   // Capture the sensed line voltage during detection [R2]
   always_ff @(posedge mclk) begin
      if (rst) begin
         sense_q <= '0;
         sense_valid_q <= 1'b0;
      end else begin
         sense_valid_q <= adc_valid && st_q == ST_PS;
         if (adc_valid && st_q == ST_PS) begin
            sense_q <= adc_result;
         end
      end
   end
endmodule

// ---- testbench/ucd_port_properties.sv ----
/* Checker on the charger port pins.
 Assumes bind to ucd_charger_port; cfg held while a scheme runs. */
`timescale 1ns/1ns
module ucd_port_properties (
   input wire logic mclk,
   input wire logic rst,
   input wire ucd_pkg::ucd_cfg_e port_cfg,
   input wire ucd_pkg::ucd_adc_t adc_result,
   input wire logic adc_valid,
   input wire ucd_pkg::ucd_ana_s ana,
   input wire logic vbus_discharge,
   input wire ucd_pkg::ucd_adc_t sense_q,
   input wire logic sense_valid_q,
   input wire logic cdp_driving_q
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   ucd_pkg::ucd_cfg_e cfg_q;
   logic [2:0] hold_q;
   logic calm;
   assign calm = hold_q == 3'h4 && port_cfg == cfg_q; // Off on the edge a new cfg lands
   // Settle count: passing through idle takes three edges, so wait four
   always_ff @(posedge mclk) begin
      cfg_q <= port_cfg;
      if (rst || port_cfg != cfg_q) begin
         hold_q <= 3'h0;
      end else if (!calm) begin
         hold_q <= hold_q + 3'h1;
      end
   end
   dcd_phase_a: assert property (
      calm |-> ana.dplus_contact_current_source == (port_cfg == ucd_pkg::UCD_CFG_DCD))
      else $error("contact source wrong for scheme");
   dcd_pair_a: assert property (
      ana.dplus_contact_current_source == ana.dminus_pulldown_resistor)
      else $error("contact source and pulldown differ");
   src_sink_a: assert property (
      calm |-> ana.data_line_current_sink == (port_cfg inside
      {ucd_pkg::UCD_CFG_PRI_SEC, ucd_pkg::UCD_CFG_CDP}) &&
      ana.data_line_voltage_source == ana.data_line_current_sink)
      else $error("source or sink wrong for scheme");
   div_both_a: assert property (
      ana.divider_on_dplus == ana.divider_on_dminus)
      else $error("divider on one line only");
   low_short_a: assert property (ana.v1p2_on_dminus |-> ana.data_line_short_resistor)
      else $error("1.2 V mode without short");
   keep_vbus_a: assert property (!vbus_discharge)
      else $error("vbus discharge raised");
   one_scheme_a: assert property (
      !(ana.data_line_short_resistor && (ana.data_line_voltage_source || ana.divider_on_dplus)))
      else $error("two schemes at once");
   cdp_seen_a: assert property (
      calm && port_cfg == ucd_pkg::UCD_CFG_CDP && adc_valid && adc_result >=
      ucd_pkg::CDP_SEEN_CODE |=> cdp_driving_q ##1 ana.data_line_voltage_on_dminus)
      else $error("cdp drive not started");
   sense_take_a: assert property (
      calm && port_cfg == ucd_pkg::UCD_CFG_PRI_SEC && adc_valid
      |=> sense_valid_q && sense_q == $past(adc_result))
      else $error("detection sample not captured");
endmodule
bind ucd_charger_port ucd_port_properties i_props (.mclk(mclk), .rst(rst),
   .port_cfg(port_cfg), .adc_result(adc_result), .adc_valid(adc_valid), .ana(ana),
   .vbus_discharge(vbus_discharge), .sense_q(sense_q), .sense_valid_q(sense_valid_q),
   .cdp_driving_q(cdp_driving_q));

// ---- testbench/ucd_usb_dev_model.sv ----
/* Attached device model: the ADC reads the line level the bench sets.
 Assumes one conversion every four mclk cycles. */
`timescale 1ns/1ns
module ucd_usb_dev_model (
   input wire logic mclk,
   input wire logic rst,
   input wire ucd_pkg::ucd_adc_t line_code,
   output ucd_pkg::ucd_adc_t adc_result,
   output logic adc_valid
);
   logic [1:0] tick_q;
   // Result good only in the valid cycle; inverted otherwise
   always_ff @(posedge mclk) begin
      tick_q <= rst ? 2'h0 : tick_q + 2'h1;
      adc_valid <= !rst && tick_q == 2'h3;
      adc_result <= (tick_q == 2'h3) ? line_code : ~line_code;
   end
endmodule

// ---- testbench/ucd_charger_port_tb_top.sv ----
/* Bench for ucd_charger_port with the device model on the lines.
 Assumes the long auto dwell, so only the first auto candidate shows. */
`timescale 1ns/1ns
module ucd_charger_port_tb_top;
   logic mclk, rst, on_dm, vld, sel, dis, sv, drv;
   ucd_pkg::ucd_cfg_e cfg;
   ucd_pkg::ucd_adc_t code, res, sense;
   ucd_pkg::ucd_ana_s ana;
   int num_errors, cmp_count, cyc;
   logic [8:0] exp_t [8] = '{9'h000, 9'h180, 9'h050, 9'h050, 9'h008, 9'h006, 9'h009, 9'h008};
   ucd_charger_port i_dut (.mclk(mclk), .rst(rst), .port_cfg(cfg), .pri_sec_on_dminus(on_dm),
      .adc_result(res), .adc_valid(vld), .ana(ana), .adc_sel_dminus(sel),
      .vbus_discharge(dis), .sense_q(sense), .sense_valid_q(sv), .cdp_driving_q(drv));
   ucd_usb_dev_model i_dev (.mclk(mclk), .rst(rst), .line_code(code), .adc_result(res),
      .adc_valid(vld));
   // Clock and hang guard
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 1000) begin
         num_errors++;
         wrap_up();
      end
   end
   task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic wrap_up();
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Every scheme back to back, then detection and CDP handshakes
   initial begin
      rst = 1'b1;
      cfg = ucd_pkg::UCD_CFG_OFF;
      on_dm = 1'b0;
      code = 10'h020;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      #1;
      chk("ana reset", 10'h000, {1'b0, ana});
      for (int i = 0; i < 8; i++) begin
         // Bench VBUS is ideal, well above 2.4 A for the advertisement modes
         @(posedge mclk) cfg <= ucd_pkg::ucd_cfg_e'(i[2:0]);
         settle(6);
         chk("ana scheme", {1'b0, exp_t[i]}, {1'b0, ana});
         chk("discharge", 10'h000, {9'h000, dis});
      end
      @(posedge mclk) cfg <= ucd_pkg::UCD_CFG_PRI_SEC;
      on_dm <= 1'b1;
      code <= 10'h123;
      settle(6);
      chk("pri ana", 10'h070, {1'b0, ana});
      for (int k = 0; k < 10 && sv !== 1'b1; k++) settle(1);
      chk("sense valid", 10'h001, {9'h000, sv});
      chk("sense", 10'h123, sense);
      @(posedge mclk) on_dm <= 1'b0;
      settle(4);
      chk("adc sel", 10'h001, {9'h000, sel});
      @(posedge mclk) cfg <= ucd_pkg::UCD_CFG_CDP;
      code <= 10'h010;
      settle(8);
      chk("cdp idle", 10'h050, {drv, ana});
      chk("adc sel cdp", 10'h000, {9'h000, sel});
      @(posedge mclk) code <= 10'h0aa;
      settle(8);
      chk("cdp drive", 10'h270, {drv, ana});
      @(posedge mclk) code <= 10'h010;
      settle(8);
      chk("cdp release", 10'h050, {drv, ana});
      wrap_up();
   end
endmodule
